//--- src/otf_pkg.sv
package otf_pkg;

    // Command codes of the two registers
    localparam logic [7:0]  OTF_CMD_THRESHOLD   = 8'h4F;
    localparam logic [7:0]  OTF_CMD_ACTION      = 8'h50;

    // Reset values
    localparam logic [15:0] OTF_THRESHOLD_RESET = 16'h0091;
    localparam logic [7:0]  OTF_ACTION_RESET    = 8'h3F;

    // Mantissa field, exponent field is fixed zero
    localparam int          OTF_MANT_LSB        = 0;
    localparam int          OTF_MANT_W          = 11;

    // Action register fields
    localparam int          OTF_IGNORE_BIT      = 7;
    localparam int          OTF_RETRY_MSB       = 5;
    localparam int          OTF_RETRY_LSB       = 3;

    // Supported programming range and hysteresis, degrees
    localparam logic [10:0] OTF_MANT_MIN        = 11'h078;
    localparam logic [10:0] OTF_MANT_MAX        = 11'h0A5;
    localparam logic [10:0] OTF_HYSTERESIS      = 11'h014;

    // Retry field codes
    localparam logic [2:0]  OTF_RETRY_NONE      = 3'h0;
    localparam logic [2:0]  OTF_RETRY_ALWAYS    = 3'h7;

    // Ramp durations waited before each restart
    localparam logic [3:0]  OTF_RETRY_RAMPS     = 4'h7;

    // Soft start ramp time and its count of cycles
    localparam int          OTF_CLK_HZ          = 10_000_000;
    localparam int          OTF_RAMP_US         = 1000;
    localparam int          OTF_RAMP_CYCLES     =
        (OTF_RAMP_US * (OTF_CLK_HZ / 1_000_000));

    // Register write request
    typedef struct packed {
        logic        strobe;
        logic [7:0]  command;
        logic [15:0] data;
    } otf_wr_t;

    // Status toward the summary and temperature registers
    typedef struct packed {
        logic summary_overtemp_flag;
        logic overtemp_fault_flag;
        logic comm_fault_flag;
        logic invalid_data_flag;
    } otf_status_t;

    typedef enum logic [1:0] {
        OTF_RUN      = 2'b00,
        OTF_OFF_HOLD = 2'b01,
        OTF_WAIT     = 2'b10,
        OTF_RESTART  = 2'b11
    } otf_state_t;

endpackage

//--- src/otf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module otf_sync
    import otf_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // otf_sync
`default_nettype wire

//--- src/otf_retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
module otf_retry_timer
    import otf_pkg::*;
#(
    parameter int RAMP_CYCLES = OTF_RAMP_CYCLES
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Control
    input  wire logic start,
    output logic      done
);
    localparam int CW = $clog2(RAMP_CYCLES + 1);

    logic [CW-1:0] cyc_r;
    logic [3:0]    ramps_r;
    logic          busy_r;

    // Counts seven whole ramp durations
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cyc_r   <= '0;
            ramps_r <= 4'h0;
            busy_r  <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cyc_r   <= '0;
                ramps_r <= 4'h0;
                busy_r  <= 1'b1;
            end else if (busy_r) begin
                if (cyc_r == CW'(RAMP_CYCLES - 1)) begin
                    cyc_r <= '0;
                    if (ramps_r == OTF_RETRY_RAMPS - 4'h1) begin
                        busy_r <= 1'b0;
                        done   <= 1'b1;
                    end
                    ramps_r <= ramps_r + 4'h1;
                end else begin
                    cyc_r <= cyc_r + CW'(1);
                end
            end
        end
    end
endmodule // otf_retry_timer
`default_nettype wire

//--- src/otf_fault_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module otf_fault_ctrl
    import otf_pkg::*;
#(
    parameter int RAMP_CYCLES = OTF_RAMP_CYCLES
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Register write port
    input  wire otf_wr_t      wr,
    input  wire logic         store_all_defaults,
    input  wire logic         restore_defaults,
    // Status clearing and off command by the host
    input  wire logic         clear_faults,
    input  wire logic         commanded_off,
    // Sensing, from outside the clock domain
    input  wire logic [10:0]  ext_temperature,
    input  wire logic         bandgap_overtemp,
    input  wire logic [10:0]  overtemp_warning_threshold,
    // Register read back
    output logic [15:0]       overtemp_fault_threshold,
    output logic [7:0]        overtemp_fault_action,
    output otf_status_t       status,
    output logic              smbalert_n,
    // Power stage control
    output logic              output_enable,
    output logic              soft_start_req,
    // Nonvolatile image
    output logic              nvm_write,
    output logic [10:0]       nvm_threshold,
    output logic [1:0]        nvm_action
);
    logic [10:0] temp_s;
    logic        bg_s;
    logic [10:0] mant_r;
    logic        ignore_r;
    logic        retry_r;
    logic        fault_r;
    logic        bg_fault_r;
    logic        reject;
    logic        trip;
    logic        shut_evt;
    logic        tmr_done;
    logic        tmr_start;
    logic [10:0] wmant;
    logic [2:0]  wretry;
    logic [10:0] release_lvl;
    logic [10:0] temp_prev_r;
    logic [10:0] temp_r;
    otf_state_t  state_r;
    otf_state_t  state_nxt;

    // Word is synchronised per bit and may tear; see the guard below
    otf_sync #(.W(12)) otf_sync_i (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .async_in ({bandgap_overtemp, ext_temperature}),
        .sync_out ({bg_s, temp_s})
    );

    otf_retry_timer #(.RAMP_CYCLES(RAMP_CYCLES)) otf_retry_timer_i (
        .mclk    (mclk),
        .reset_n (reset_n),
        .start   (tmr_start),
        .done    (tmr_done)
    );

    assign wmant  = wr.data[OTF_MANT_W-1:OTF_MANT_LSB];
    assign wretry = wr.data[OTF_RETRY_MSB:OTF_RETRY_LSB];

    // Validate writes
    always_comb begin
        reject = 1'b0;
        if (wr.strobe && wr.command == OTF_CMD_THRESHOLD) begin
            if (wmant <= overtemp_warning_threshold) begin
                reject = 1'b1;
            end
        end
        if (wr.strobe && wr.command == OTF_CMD_ACTION) begin
            if (wretry != OTF_RETRY_NONE && wretry != OTF_RETRY_ALWAYS) begin
                reject = 1'b1;
            end
        end
    end

    // Threshold mantissa; exponent bits are never stored
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mant_r <= OTF_THRESHOLD_RESET[10:0];
        end else if (restore_defaults) begin
            mant_r <= OTF_THRESHOLD_RESET[10:0];
        end else if (wr.strobe && !reject &&
                     wr.command == OTF_CMD_THRESHOLD) begin
            mant_r <= wmant;
        end
    end

    // Only bits 7 and 5 are held; the rest are derived
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ignore_r <= OTF_ACTION_RESET[OTF_IGNORE_BIT];
            retry_r  <= OTF_ACTION_RESET[OTF_RETRY_MSB];
        end else if (restore_defaults) begin
            ignore_r <= OTF_ACTION_RESET[OTF_IGNORE_BIT];
            retry_r  <= OTF_ACTION_RESET[OTF_RETRY_MSB];
        end else if (wr.strobe && !reject &&
                     wr.command == OTF_CMD_ACTION) begin
            ignore_r <= wr.data[OTF_IGNORE_BIT];
            retry_r  <= wr.data[OTF_RETRY_MSB];
        end
    end

    // Read back, delay bits mirror bit 5
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            overtemp_fault_threshold <= OTF_THRESHOLD_RESET;
            overtemp_fault_action    <= OTF_ACTION_RESET;
        end else begin
            overtemp_fault_threshold <= {5'h00, mant_r};
            overtemp_fault_action    <= {ignore_r, 1'b0, {3{retry_r}},
                                         {3{retry_r}}};
        end
    end

    // Save strobe toward the nonvolatile store
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            nvm_write <= 1'b0;
        end else begin
            nvm_write <= store_all_defaults;
        end
    end

    // Nonvolatile save holds one retry bit only
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            nvm_threshold <= 11'h000;
            nvm_action    <= 2'h0;
        end else if (store_all_defaults) begin
            nvm_threshold <= mant_r;
            nvm_action    <= {ignore_r, retry_r};
        end
    end

    // A word caught mid-change differs between two samples, so only a
    // word seen twice in a row is used; a pin that never settles keeps
    // the last steady value
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            temp_prev_r <= 11'h000;
            temp_r      <= 11'h000;
        end else begin
            temp_prev_r <= temp_s;
            if (temp_s == temp_prev_r) begin
                temp_r <= temp_s;
            end
        end
    end

    // Trip above threshold, release at threshold less hysteresis
    assign release_lvl = (mant_r > OTF_HYSTERESIS) ?
                         (mant_r - OTF_HYSTERESIS) : 11'h000;
    assign trip = !fault_r && (temp_r > mant_r);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fault_r <= 1'b0;
        end else if (trip) begin
            fault_r <= 1'b1;
        end else if (fault_r && temp_r <= release_lvl) begin
            fault_r <= 1'b0;
        end
    end

    // Internal detector is a single bit; no tear guard needed
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bg_fault_r <= 1'b0;
        end else begin
            bg_fault_r <= bg_s;
        end
    end

    // Sticky status; a new event wins over a clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            status <= '0;
        end else begin
            if (trip || fault_r) begin
                status.summary_overtemp_flag <= 1'b1;
                status.overtemp_fault_flag   <= 1'b1;
            end else if (clear_faults) begin
                status.summary_overtemp_flag <= 1'b0;
                status.overtemp_fault_flag   <= 1'b0;
            end
            if (reject) begin
                status.comm_fault_flag   <= 1'b1;
                status.invalid_data_flag <= 1'b1;
            end else if (clear_faults) begin
                status.comm_fault_flag   <= 1'b0;
                status.invalid_data_flag <= 1'b0;
            end
        end
    end

    // No mask register here; every set flag raises the alert
    // Alert follows any set status, also in ignore mode
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            smbalert_n <= 1'b1;
        end else begin
            smbalert_n <= !(trip || reject || (|status));
        end
    end

    // Bandgap fault shuts down even when ignore is selected
    assign shut_evt = (fault_r && ignore_r) || bg_fault_r;
    // Timer runs only once both detectors have cleared
    assign tmr_start = (state_r == OTF_OFF_HOLD) && retry_r &&
                       !fault_r && !bg_fault_r && !commanded_off;

    // A shutdown event or off command during the wait aborts it; the count restarts later
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            OTF_RUN: begin
                if (shut_evt) begin
                    state_nxt = OTF_OFF_HOLD;
                end
            end
            OTF_OFF_HOLD: begin
                // Restart only once cooled
                if (tmr_start) begin
                    state_nxt = OTF_WAIT;
                end else if (!retry_r && clear_faults && !shut_evt) begin
                    state_nxt = OTF_RUN;
                end
            end
            OTF_WAIT: begin
                if (shut_evt || commanded_off) begin
                    state_nxt = OTF_OFF_HOLD;
                end else if (tmr_done) begin
                    state_nxt = OTF_RESTART;
                end
            end
            OTF_RESTART: begin
                state_nxt = OTF_RUN;
            end
            default: begin
                state_nxt = OTF_OFF_HOLD;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= OTF_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Follows the next state so the output drops on the shutdown edge
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            output_enable <= 1'b1;
        end else begin
            output_enable <= (state_nxt == OTF_RUN) ||
                             (state_nxt == OTF_RESTART);
        end
    end

    // One pulse per restart, with the output turned back on
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            soft_start_req <= 1'b0;
        end else begin
            soft_start_req <= (state_nxt == OTF_RESTART);
        end
    end
endmodule // otf_fault_ctrl
`default_nettype wire

//--- test/otf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module otf_host_model
    import otf_pkg::*;
(
    // Clock
    input  wire logic mclk,
    // Host requests
    output otf_wr_t   wr,
    output logic      clear_faults
);
    initial begin
        wr = '0;
        clear_faults = 1'b0;
    end
    // Whole word in one strobe; returns once readback has landed
    task automatic write(input logic [7:0] cmd, input logic [15:0] dat);
        @(negedge mclk);
        wr <= '{1'b1, cmd, dat};
        @(negedge mclk);
        wr.strobe <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic clear_pulse();
        @(negedge mclk);
        clear_faults <= 1'b1;
        @(negedge mclk);
        clear_faults <= 1'b0;
    endtask
endmodule // otf_host_model
`default_nettype wire

//--- test/otf_fault_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module otf_fault_ctrl_properties
    import otf_pkg::*;
#(
    parameter int RAMP_CYCLES = OTF_RAMP_CYCLES
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Requests
    input wire otf_wr_t     wr,
    input wire logic        store_all_defaults,
    input wire logic        bandgap_overtemp,
    input wire logic [10:0] overtemp_warning_threshold,
    // Outputs
    input wire logic [15:0] overtemp_fault_threshold,
    input wire logic [7:0]  overtemp_fault_action,
    input wire otf_status_t status,
    input wire logic        smbalert_n,
    input wire logic        output_enable,
    input wire logic        nvm_write,
    input wire logic [10:0] nvm_threshold,
    input wire logic [1:0]  nvm_action
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic bad_act;
    logic bad_thr;
    assign bad_act = wr.strobe && wr.command == OTF_CMD_ACTION
        && wr.data[5:3] != 3'h0 && wr.data[5:3] != 3'h7;
    assign bad_thr = wr.strobe && wr.command == OTF_CMD_THRESHOLD
        && wr.data[10:0] <= overtemp_warning_threshold;
    sequence s_flagged;
        status.comm_fault_flag && status.invalid_data_flag && !smbalert_n;
    endsequence
    a_bad_retry_flag: assert property (bad_act |=> s_flagged)
        else $error("bad retry write not flagged");
    a_bad_thr_flag: assert property (bad_thr |=> s_flagged)
        else $error("bad threshold write not flagged");
    a_reject_keeps: assert property ((bad_act || bad_thr) &&
        !$past(wr.strobe) |-> ##2
        overtemp_fault_action == $past(overtemp_fault_action, 2) &&
        overtemp_fault_threshold == $past(overtemp_fault_threshold, 2))
        else $error("rejected write changed a register");
    a_exp_zero: assert property (overtemp_fault_threshold[15:11] == 5'h00)
        else $error("threshold exponent not zero");
    a_delay_copy: assert property (overtemp_fault_action[6:0] ==
        {1'b0, {6{overtemp_fault_action[5]}}})
        else $error("action bits not copies of bit 5");
    a_fault_alert: assert property ($rose(status.overtemp_fault_flag)
        |-> status.summary_overtemp_flag && !smbalert_n)
        else $error("fault without summary flag or alert");
    a_bandgap_off: assert property (bandgap_overtemp[*4]
        |-> ##[0:4] !output_enable)
        else $error("internal overtemperature not shut down");
    a_store_nvm: assert property (store_all_defaults |=> nvm_write &&
        nvm_threshold == overtemp_fault_threshold[10:0] && nvm_action ==
        {overtemp_fault_action[7], overtemp_fault_action[5]})
        else $error("store did not save registers");
endmodule // otf_fault_ctrl_properties
bind otf_fault_ctrl otf_fault_ctrl_properties #(
    .RAMP_CYCLES(RAMP_CYCLES)
) otf_fault_ctrl_properties_i (.mclk, .reset_n, .wr, .store_all_defaults,
    .bandgap_overtemp, .overtemp_warning_threshold,
    .overtemp_fault_threshold, .overtemp_fault_action, .status,
    .smbalert_n, .output_enable, .nvm_write, .nvm_threshold, .nvm_action);
`default_nettype wire

//--- test/otf_fault_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module otf_fault_ctrl_bench import otf_pkg::*;;
    localparam int RAMP = 4;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        store = 1'b0;
    logic        bandgap = 1'b0;
    logic        off = 1'b0;
    logic [10:0] temp = 11'h019;
    logic [10:0] warn = 11'h078;
    otf_wr_t     wr;
    logic        clear;
    logic [15:0] thr;
    logic [7:0]  act;
    otf_status_t st;
    logic        alert_n, oe, ss_req, nvm_wr;
    logic [10:0] nvm_thr;
    logic [1:0]  nvm_act;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #50 mclk = ~mclk;
    otf_host_model otf_host_model_i (.mclk(mclk), .wr(wr), .clear_faults(clear));
    otf_fault_ctrl #(.RAMP_CYCLES(RAMP)) otf_fault_ctrl_i (.mclk(mclk),
        .reset_n(reset_n), .wr(wr), .store_all_defaults(store),
        .restore_defaults(1'b0), .clear_faults(clear), .commanded_off(off),
        .ext_temperature(temp), .bandgap_overtemp(bandgap),
        .overtemp_warning_threshold(warn), .overtemp_fault_threshold(thr),
        .overtemp_fault_action(act), .status(st), .smbalert_n(alert_n),
        .output_enable(oe), .soft_start_req(ss_req), .nvm_write(nvm_wr),
        .nvm_threshold(nvm_thr), .nvm_action(nvm_act));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded so a stuck output cannot hang the run
    task automatic wait_oe(input logic v, output int n);
        n = 0;
        while (oe !== v && n < 200) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic t_regs();
        check(thr, 16'h0091);
        check(16'(act), 16'h003F);
        check(16'({st, alert_n, oe}), 16'h0003);
        otf_host_model_i.write(OTF_CMD_THRESHOLD, 16'h0078);
        check(16'({st.comm_fault_flag, st.invalid_data_flag}), 16'h3);
        check(thr, 16'h0091);
        otf_host_model_i.clear_pulse();
        otf_host_model_i.write(OTF_CMD_THRESHOLD, 16'hF8A0);
        check(thr, 16'h00A0);
    endtask
    task automatic t_retry_codes();
        logic [7:0] want;
        for (int c = 0; c < 8; c++) begin
            want = (c == 7) ? 8'hBF : 8'h80;
            otf_host_model_i.clear_pulse();
            otf_host_model_i.write(OTF_CMD_ACTION, {8'h00, 2'b11, 3'(c), 3'h0});
            check(16'(act), 16'(want));
            check(16'(st.invalid_data_flag), 16'(c != 0 && c != 7));
        end
        @(negedge mclk);
        store <= 1'b1;
        @(negedge mclk);
        store <= 1'b0;
        check(16'({nvm_wr, nvm_act}), 16'h0007);
        check(16'(nvm_thr), 16'h00A0);
    endtask
    task automatic t_restart();
        int n;
        repeat (2) begin
            temp = 11'h0A1;
            wait_oe(1'b0, n);
            check(16'(n < 10), 16'h1);
            check(16'({st.overtemp_fault_flag, alert_n}), 16'h0002);
            temp = 11'h08C;
            wait_oe(1'b1, n);
            check(16'(n >= 7 * RAMP && n < 7 * RAMP + 20), 16'h1);
            check(16'(ss_req), 16'h1);
        end
    endtask
    task automatic t_ignore();
        otf_host_model_i.write(OTF_CMD_ACTION, 16'h0038);
        otf_host_model_i.clear_pulse();
        temp = 11'h0A0;
        repeat (8) @(negedge mclk);
        check(16'(st.overtemp_fault_flag), 16'h0);
        temp = 11'h0A1;
        repeat (8) @(negedge mclk);
        check(16'({st.overtemp_fault_flag, oe}), 16'h3);
        temp = 11'h08D;
        repeat (8) @(negedge mclk);
        otf_host_model_i.clear_pulse();
        check(16'(st.overtemp_fault_flag), 16'h1);
        temp = 11'h08C;
        repeat (8) @(negedge mclk);
        otf_host_model_i.clear_pulse();
        check(16'(st.overtemp_fault_flag), 16'h0);
    endtask
    task automatic t_latch_and_bandgap();
        int n;
        otf_host_model_i.write(OTF_CMD_ACTION, 16'h0080);
        check(16'(act), 16'h0080);
        temp = 11'h0A1;
        wait_oe(1'b0, n);
        temp = 11'h08C;
        repeat (60) @(negedge mclk);
        check(16'({oe, ss_req}), 16'h0);
        otf_host_model_i.clear_pulse();
        wait_oe(1'b1, n);
        check(16'(n < 10), 16'h1);
        otf_host_model_i.write(OTF_CMD_ACTION, 16'h0038);
        bandgap = 1'b1;
        wait_oe(1'b0, n);
        check(16'(n < 10), 16'h1);
        bandgap = 1'b0;
        off = 1'b1;
        repeat (60) @(negedge mclk);
        check(16'(oe), 16'h0);
        off = 1'b0;
        wait_oe(1'b1, n);
        check(16'(n >= 7 * RAMP && n < 7 * RAMP + 20), 16'h1);
        check(16'(ss_req), 16'h1);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        t_regs();
        t_retry_codes();
        t_restart();
        t_ignore();
        t_latch_and_bandgap();
        stop_test();
    end
endmodule // otf_fault_ctrl_bench
`default_nettype wire
